// ### src/lce_evaluator.sv
// Ladder rung execution-condition evaluator: block stack, joins, inverter, edge pulses.
// Assumes a sequencer on clk_i feeding one step per cycle and marking rung start and end.
`timescale 1ns/100ps
module lce_evaluator
    import lce_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Program step from the sequencer
    input wire logic step_valid_i,
    input wire lce_step_type step_i,
    input wire logic section_cond_i,
    input wire logic sub_exec_i,
    // Flags owned by the arithmetic unit, held here
    input wire logic flags_we_i,
    input wire logic [FLAG_W-1:0] flags_i,
    output logic [FLAG_W-1:0] flags_o,
    // Condition and rung results
    output logic cond_o,
    output logic rung_done_o,
    output logic rung_cond_o,
    output logic count_err_o,
    output logic depth_err_o,
    output logic tail_err_o
);

    lce_state_type q;
    lce_state_type d;
    logic take;
    logic [TOP_W-1:0] top_idx;
    logic top_bit;
    logic edge_in;
    logic hist_bit;

    // An uncalled subroutine executes nothing, edge history included
    assign take = step_valid_i && sub_exec_i;
    assign top_idx = TOP_W'(q.sp - SP_ONE);
    assign top_bit = q.stack[top_idx];
    assign edge_in = q.cond & section_cond_i;
    // One history bit per element index; repeated calls reuse the same bit
    assign hist_bit = q.hist[step_i.elem];

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (flags_we_i) begin
            d.flags = flags_i;
        end
        if (take) begin
            d.last_inv = (step_i.op == OP_COND_INVERT);
            case (step_i.op)
                OP_RUNG_START: begin
                    d.phase = PH_RUNG;
                    d.sp = SP_ZERO;
                    d.stack = '0;
                    d.loads = CNT_ZERO;
                    d.joins = CNT_ZERO;
                    d.cond = 1'b0;
                    d.count_err = 1'b0;
                    d.depth_err = 1'b0;
                    d.tail_err = 1'b0;
                end
                OP_BLOCK_START_LOAD, OP_BLOCK_START_INVERTED: begin
                    // A new load closes the running block and parks it
                    if (q.loads != CNT_ZERO) begin
                        if (q.sp == SP_FULL) begin
                            d.depth_err = 1'b1;
                        end else begin
                            d.stack[TOP_W'(q.sp)] = q.cond;
                            d.sp = q.sp + SP_ONE;
                            // Eight stacked plus the running block make nine pending loads
                            if (d.sp == SP_FULL) begin
                                d.depth_err = 1'b1;
                            end
                        end
                    end
                    d.cond = step_i.bit_val ^ (step_i.op == OP_BLOCK_START_INVERTED);
                    if (q.loads != CNT_MAX) begin
                        d.loads = q.loads + CNT_ONE;
                    end
                end
                OP_SERIES_BLOCK_JOIN, OP_PARALLEL_BLOCK_JOIN: begin
                    if (q.joins != CNT_MAX) begin
                        d.joins = q.joins + CNT_ONE;
                    end
                    // A join with nothing pending can never balance the rung
                    if (q.sp == SP_ZERO) begin
                        d.count_err = 1'b1;
                    end else begin
                        d.sp = q.sp - SP_ONE;
                        if (step_i.op == OP_SERIES_BLOCK_JOIN) begin
                            d.cond = q.cond & top_bit;
                        end else begin
                            d.cond = q.cond | top_bit;
                        end
                    end
                end
                OP_COND_INVERT: begin
                    d.cond = ~q.cond;
                end
                OP_RISE_PULSE: begin
                    d.cond = edge_in & ~hist_bit;
                    d.hist[step_i.elem] = edge_in;
                end
                OP_FALL_PULSE: begin
                    d.cond = ~edge_in & hist_bit;
                    d.hist[step_i.elem] = edge_in;
                end
                OP_RUNG_END: begin
                    d.phase = PH_DONE;
                    d.done = 1'b1;
                    d.rung_cond = q.cond;
                    if (q.joins != q.loads - CNT_ONE) begin
                        d.count_err = 1'b1;
                    end
                    // Reported only; the sequencer owns this mistake
                    d.tail_err = q.last_inv;
                end
                default: begin
                    d.last_inv = q.last_inv;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{phase: PH_IDLE, flags: FLAGS_RST, default: '0};
        end else begin
            q <= d;
        end
    end

    assign flags_o = q.flags;
    assign cond_o = q.cond;
    assign rung_done_o = q.done;
    assign rung_cond_o = q.rung_cond;
    assign count_err_o = q.count_err;
    assign depth_err_o = q.depth_err;
    assign tail_err_o = q.tail_err;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rung_open;
        take && step_i.op == OP_RUNG_START;
    endsequence

    sequence s_rung_clean;
        q.sp == SP_ZERO && q.loads == CNT_ZERO && !count_err_o && !depth_err_o;
    endsequence

    sequence s_done_flagged;
        rung_done_o && count_err_o ##1 !rung_done_o;
    endsequence

    a_stack_cleared: assert property (s_rung_open |=> s_rung_clean)
        else $error("Rung start left stack or errors set");

    a_series_and: assert property (take && step_i.op == OP_SERIES_BLOCK_JOIN
        && q.sp != SP_ZERO |=> cond_o == ($past(q.cond) & $past(top_bit))
        && q.sp == $past(q.sp) - SP_ONE)
        else $error("Series join result wrong");

    a_parallel_or: assert property (take && step_i.op == OP_PARALLEL_BLOCK_JOIN
        && q.sp != SP_ZERO |=> cond_o == ($past(q.cond) | $past(top_bit)))
        else $error("Parallel join result wrong");

    a_block_push: assert property (take && step_i.op == OP_BLOCK_START_LOAD
        && q.loads != CNT_ZERO && q.sp != SP_FULL
        |=> q.sp == $past(q.sp) + SP_ONE && cond_o == $past(step_i.bit_val))
        else $error("Block start did not push");

    a_depth_limit: assert property (take && q.loads != CNT_ZERO
        && (step_i.op == OP_BLOCK_START_LOAD || step_i.op == OP_BLOCK_START_INVERTED)
        && q.sp >= SP_FULL - SP_ONE |=> depth_err_o)
        else $error("Ninth pending block not flagged");

    a_count_check: assert property (take && step_i.op == OP_RUNG_END
        && q.joins != q.loads - CNT_ONE |=> s_done_flagged)
        else $error("Join count mismatch not flagged");

    a_empty_join: assert property (take && q.sp == SP_ZERO
        && (step_i.op == OP_SERIES_BLOCK_JOIN || step_i.op == OP_PARALLEL_BLOCK_JOIN)
        |=> count_err_o && cond_o == $past(cond_o))
        else $error("Join on empty stack not flagged");

    a_invert_cond: assert property (take && step_i.op == OP_COND_INVERT
        |=> cond_o != $past(cond_o))
        else $error("Inverter did not complement");

    a_rise_once: assert property (take && step_i.op == OP_RISE_PULSE && hist_bit
        |=> !cond_o)
        else $error("Rising pulse held past one scan");

    a_fall_edge: assert property (take && step_i.op == OP_FALL_PULSE
        |=> cond_o == (!$past(edge_in) && $past(hist_bit)))
        else $error("Falling pulse wrong");

    a_tail_report: assert property (take && step_i.op == OP_RUNG_END
        |=> tail_err_o == $past(q.last_inv))
        else $error("Inverter at rung end not reported");

    a_skip_hist: assert property (!sub_exec_i |=> $stable(q.hist) && $stable(cond_o))
        else $error("Uncalled subroutine changed state");

    a_flags_hold: assert property (!flags_we_i |=> $stable(flags_o))
        else $error("Flags changed by condition step");

endmodule // lce_evaluator

// ### src/lce_pkg.sv
// Package for the ladder condition evaluator: opcodes, step carrier, state record.
// Assumes one clock; the sequencer issues at most one step per cycle.
package lce_pkg;

    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 4;
    localparam int TOP_W = 3;
    localparam int HIST_N = 16;
    localparam int HIST_W = 4;
    localparam int CNT_W = 8;
    localparam int FLAG_W = 4;

    localparam logic [SP_W-1:0] SP_ZERO = 4'h0;
    localparam logic [SP_W-1:0] SP_ONE = 4'h1;
    localparam logic [SP_W-1:0] SP_FULL = 4'h8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;

    // Opcodes; the inverter and pulse elements carry their function codes 520, 521, 522
    typedef enum logic [9:0] {
        OP_NOP = 10'h000,
        OP_RUNG_START = 10'h001,
        OP_RUNG_END = 10'h002,
        OP_BLOCK_START_LOAD = 10'h003,
        OP_BLOCK_START_INVERTED = 10'h004,
        OP_SERIES_BLOCK_JOIN = 10'h005,
        OP_PARALLEL_BLOCK_JOIN = 10'h006,
        OP_COND_INVERT = 10'h208,
        OP_RISE_PULSE = 10'h209,
        OP_FALL_PULSE = 10'h20a
    } lce_op_type;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_RUNG = 2'b01,
        PH_DONE = 2'b11
    } lce_phase_type;

    typedef struct packed {
        lce_op_type op;
        logic bit_val;
        logic [HIST_W-1:0] elem;
    } lce_step_type;

    typedef struct packed {
        lce_phase_type phase;
        logic cond;
        logic [STACK_DEPTH-1:0] stack;
        logic [SP_W-1:0] sp;
        logic [CNT_W-1:0] loads;
        logic [CNT_W-1:0] joins;
        logic [HIST_N-1:0] hist;
        logic [FLAG_W-1:0] flags;
        logic done;
        logic rung_cond;
        logic count_err;
        logic depth_err;
        logic tail_err;
        logic last_inv;
    } lce_state_type;

endpackage

// ### verif/lce_seq_model.sv
// Sequencer model: presents one ladder program step per call, back to back.
// Assumes the evaluator takes a step at every rising clk_i edge.
`timescale 1ns/100ps
module lce_seq_model
    import lce_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Step toward the evaluator
    output logic step_valid_o,
    output lce_step_type step_o,
    output logic section_cond_o,
    output logic sub_exec_o
);
    initial begin
        step_valid_o = 1'b0;
        step_o = '{OP_NOP, 1'b0, 4'h0};
        section_cond_o = 1'b1;
        sub_exec_o = 1'b1;
    end
    // Rung shape is the caller's choice, so bad programs can be sent on purpose
    task automatic issue(input lce_op_type op, input logic b = 1'b0,
            input logic [HIST_W-1:0] e = 4'h0, input logic s = 1'b1, input logic x = 1'b1);
        step_valid_o <= 1'b1;
        step_o <= '{op, b, e};
        section_cond_o <= s;
        sub_exec_o <= x;
        @(posedge clk_i);
    endtask
    // Idle operand flips so a stale value never looks valid
    task automatic rest();
        step_valid_o <= 1'b0;
        step_o.bit_val <= ~step_o.bit_val;
        @(posedge clk_i);
    endtask
endmodule // lce_seq_model

// ### verif/tb_top.sv
// Bench for the ladder condition evaluator: joins, depth, counts, inverter, pulses.
// Assumes the sequencer model drives steps; held flags are written from here.
`timescale 1ns/100ps
module tb_top
    import lce_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic flags_we = 1'b0;
    logic [FLAG_W-1:0] flags = 4'h0;
    logic [FLAG_W-1:0] flags_o;
    logic valid, sec, sub, cond, done, rcond, cerr, derr, terr;
    lce_step_type step;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #2.5 clk_i = ~clk_i;
    lce_seq_model lce_seq_model_i (.clk_i(clk_i), .step_valid_o(valid), .step_o(step),
        .section_cond_o(sec), .sub_exec_o(sub));
    lce_evaluator lce_evaluator_i (.clk_i(clk_i), .rst_i(rst_i), .step_valid_i(valid),
        .step_i(step), .section_cond_i(sec), .sub_exec_i(sub), .flags_we_i(flags_we),
        .flags_i(flags), .flags_o(flags_o), .cond_o(cond), .rung_done_o(done),
        .rung_cond_o(rcond), .count_err_o(cerr), .depth_err_o(derr), .tail_err_o(terr));
    task automatic conclude();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [4:0] seen, input logic [4:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic go(input lce_op_type op, input logic b = 1'b0);
        lce_seq_model_i.issue(op, b);
    endtask
    task automatic end_rung(input logic [4:0] exp);
        go(OP_RUNG_END);
        // Sample while the done pulse stands; the idle step still goes out on the edge
        fork
            lce_seq_model_i.rest();
            #1 check({done, rcond, cerr, derr, terr}, exp);
        join
    endtask
    // Every operand pair, series and parallel; second block opens inverted
    task automatic s_joins();
        for (int i = 0; i < 8; i++) begin
            go(OP_RUNG_START);
            go(OP_BLOCK_START_LOAD, i[1]);
            go(OP_BLOCK_START_INVERTED, ~i[0]);
            go(lce_op_type'(i[2] ? OP_PARALLEL_BLOCK_JOIN : OP_SERIES_BLOCK_JOIN));
            end_rung({1'b1, i[2] ? (i[1] | i[0]) : (i[1] & i[0]), 3'b000});
        end
    endtask
    // Eight blocks, seven deferred: mixed joins only come out 1 if popped last-in first
    task automatic s_deep();
        go(OP_RUNG_START);
        for (int k = 0; k < 8; k++) begin
            go(OP_BLOCK_START_LOAD, k != 1 && k != 6);
        end
        for (int k = 0; k < 7; k++) begin
            go(lce_op_type'(k == 6 ? OP_PARALLEL_BLOCK_JOIN : OP_SERIES_BLOCK_JOIN));
        end
        end_rung(5'b11000);
        go(OP_RUNG_START);
        for (int k = 0; k < 9; k++) begin
            go(OP_BLOCK_START_LOAD, 1'b1);
        end
        fork
            go(OP_RUNG_END);
            #1 check(5'(derr), 5'h01);
        join
        lce_seq_model_i.rest();
    endtask
    task automatic s_count_inv();
        go(OP_RUNG_START);
        go(OP_BLOCK_START_LOAD, 1'b1);
        go(OP_BLOCK_START_LOAD, 1'b1);
        end_rung(5'b11100);
        go(OP_RUNG_START);
        go(OP_BLOCK_START_LOAD, 1'b0);
        go(OP_SERIES_BLOCK_JOIN);
        end_rung(5'b10100);
        go(OP_RUNG_START);
        go(OP_BLOCK_START_LOAD, 1'b0);
        go(OP_COND_INVERT);
        fork
            end_rung(5'b11001);
            #1 check(5'(cond), 5'h01);
        join
    endtask
    // Each entry is one scan: operand, section, subroutine called, expected result
    task automatic s_pulse();
        logic [3:0] v [10];
        lce_op_type op;
        logic [HIST_W-1:0] e;
        v = '{4'hf, 4'he, 4'ha, 4'hf, 4'h5, 4'he, 4'h6, 4'he, 4'h7, 4'h6};
        for (int i = 0; i < 10; i++) begin
            op = lce_op_type'(i < 6 ? OP_RISE_PULSE : OP_FALL_PULSE);
            e = i < 6 ? 4'h3 : 4'h7;
            lce_seq_model_i.issue(OP_RUNG_START, 1'b0, 4'h0, 1'b1, v[i][1]);
            lce_seq_model_i.issue(OP_BLOCK_START_LOAD, v[i][3], 4'h0, 1'b1, v[i][1]);
            lce_seq_model_i.issue(op, 1'b0, e, v[i][2], v[i][1]);
            lce_seq_model_i.issue(OP_RUNG_END, 1'b0, 4'h0, 1'b1, v[i][1]);
            fork
                lce_seq_model_i.rest();
                #1 check(5'(rcond), 5'(v[i][0]));
            join
        end
        check({1'b0, flags_o}, 5'h0a);
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check({done, rcond, cerr, derr, terr}, 5'h00);
        check({1'b0, flags_o}, 5'h00);
        @(posedge clk_i);
        flags_we <= 1'b1;
        flags <= 4'ha;
        @(posedge clk_i);
        flags_we <= 1'b0;
        flags <= 4'h5;
        s_joins();
        s_deep();
        s_count_inv();
        s_pulse();
        conclude();
    end
endmodule // tb_top
